// ==== rtl/nvac_ctrl.sv ====
`timescale 1ns/10ps
`include "nvac_defines.svh"
// Nonvolatile byte store access controller on the core's I/O space
module nvac_ctrl #(
  parameter int WR_TICKS = `NVAC_WR_TICKS,
  parameter int OSC_DIV = `NVAC_OSC_DIV
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_nrst,
  // I/O-space access from core
  input wire nvac_pkg::nvac_io_req_t i_io,
  input wire logic i_bit_op,
  output logic [7:0] o_rdata,
  output logic o_hit,
  // Core status
  input wire logic i_gie,
  input wire logic i_flash_selfprog_active,
  // Core stall, ready interrupt and busy
  output logic o_stall,
  output logic o_ready_irq,
  output logic o_busy
);

  initial begin
    if (WR_TICKS < 1 || WR_TICKS > 16383) $error("nvac_ctrl: WR_TICKS out of range");
    if (OSC_DIV < 2) $error("nvac_ctrl: OSC_DIV too small");
  end

  // State
  nvac_pkg::nvac_state_t state_q, state_d;
  logic [8:0] addr_q;
  logic [7:0] data_q;
  logic rdy_ie_q;
  logic arm_q;
  logic [2:0] arm_cnt_q;
  logic [13:0] tick_cnt_q;
  logic [2:0] stall_q;
  logic tick;
  logic [7:0] store_rdata;
  nvac_pkg::nvac_mem_req_t mem_req;

  // Decode
  wire logic io_ok = (i_io.addr <= `NVAC_IO_LAST);
  wire logic bitop_ok = !i_bit_op || (i_io.addr <= `NVAC_IO_BIT_LAST);
  wire logic wr_en = i_io.wr && io_ok && bitop_ok;
  wire logic hit_ah = (i_io.addr == `NVAC_ADDR_HIGH_IO);
  wire logic hit_al = (i_io.addr == `NVAC_ADDR_LOW_IO);
  wire logic hit_dr = (i_io.addr == `NVAC_DATA_IO);
  wire logic hit_cr = (i_io.addr == `NVAC_CTRL_IO);
  wire logic writing = (state_q == nvac_pkg::NVAC_WRITING);
  wire logic ctrl_wr = wr_en && hit_cr;
  wire logic arm_set = ctrl_wr && i_io.wdata[`NVAC_ARM_BIT];
  wire logic wstb_set = ctrl_wr && i_io.wdata[`NVAC_WSTB_BIT];
  wire logic rstb_set = ctrl_wr && i_io.wdata[`NVAC_RSTB_BIT];
  // Write starts only while armed, idle, and flash not programming
  wire logic wr_start = wstb_set && arm_q && !writing && !i_flash_selfprog_active;
  wire logic rd_go = rstb_set && !writing;
  wire logic wr_done = writing && tick && (tick_cnt_q == 14'(WR_TICKS - 1));
  wire logic [7:0] ctrl_rd = {4'h0, rdy_ie_q, arm_q, writing, 1'b0};

  nvac_tick #(
    .DIV(OSC_DIV)
  ) u_tick (
    .i_clk(i_clk),
    .i_nrst(i_nrst),
    .o_tick(tick)
  );

  assign mem_req.rd = rd_go;
  assign mem_req.wr = wr_done;
  assign mem_req.addr = addr_q;
  assign mem_req.wdata = data_q;

  nvac_store #(
    .DEPTH(512)
  ) u_store (
    .i_clk(i_clk),
    .i_req(mem_req),
    .o_rdata(store_rdata)
  );

  // Next state
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      nvac_pkg::NVAC_IDLE: begin
        if (wr_start) begin
          state_d = nvac_pkg::NVAC_WRITING;
        end
      end
      nvac_pkg::NVAC_WRITING: begin
        if (wr_done) begin
          state_d = nvac_pkg::NVAC_IDLE;
        end
      end
      default: begin
        state_d = nvac_pkg::NVAC_IDLE;
      end
    endcase
  end

  // Write state; reset does not abort a write in progress
  always_ff @(posedge i_clk) begin
    state_q <= state_d;
    if (!writing) begin
      tick_cnt_q <= 14'h0000;
    end else if (tick) begin
      tick_cnt_q <= tick_cnt_q + 14'h0001;
    end
  end

  // Address register, no reset value, frozen while writing
  always_ff @(posedge i_clk) begin
    if (wr_en && hit_al && !writing) begin
      addr_q[7:0] <= i_io.wdata;
    end
    if (wr_en && hit_ah && !writing) begin
      addr_q[8] <= i_io.wdata[0];
    end
  end

  // Data register: written by core or loaded by a read
  always_ff @(posedge i_clk) begin
    if (rd_go) begin
      data_q <= store_rdata;
    end else if (wr_en && hit_dr) begin
      data_q <= i_io.wdata;
    end
  end

  // Control: interrupt enable and arm timer
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      rdy_ie_q <= 1'b0;
      arm_q <= 1'b0;
      arm_cnt_q <= 3'h0;
    end else begin
      if (ctrl_wr) begin
        rdy_ie_q <= i_io.wdata[`NVAC_RDY_IE_BIT];
      end
      if (arm_set) begin
        arm_q <= 1'b1;
        arm_cnt_q <= `NVAC_ARM_CYCLES;
      end else if (arm_cnt_q != 3'h0) begin
        arm_cnt_q <= arm_cnt_q - 3'h1;
        arm_q <= (arm_cnt_q != 3'h1);
      end
    end
  end

  // Core stall counter
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      stall_q <= 3'h0;
    end else if (rd_go) begin
      stall_q <= `NVAC_RD_STALL;
    end else if (wr_start) begin
      stall_q <= `NVAC_WR_STALL;
    end else if (stall_q != 3'h0) begin
      stall_q <= stall_q - 3'h1;
    end
  end

  // Read mux; other addresses answer zero
  assign o_hit = io_ok && (hit_ah || hit_al || hit_dr || hit_cr);
  assign o_rdata = hit_ah ? {7'h00, addr_q[8]} :
                   hit_al ? addr_q[7:0] :
                   hit_dr ? data_q :
                   hit_cr ? ctrl_rd : 8'h00;
  assign o_stall = (stall_q != 3'h0);
  assign o_ready_irq = rdy_ie_q && i_gie && !writing;
  assign o_busy = writing;
endmodule

// ==== rtl/nvac_defines.svh ====
`ifndef NVAC_DEFINES_SVH
`define NVAC_DEFINES_SVH

// I/O space
`define NVAC_IO_LAST 6'h3F
`define NVAC_IO_BIT_LAST 6'h1F
`define NVAC_DS_OFFSET 7'h20

// Register I/O addresses
`define NVAC_ADDR_HIGH_IO 6'h1F
`define NVAC_ADDR_LOW_IO 6'h1E
`define NVAC_DATA_IO 6'h1D
`define NVAC_CTRL_IO 6'h1C

// Control field positions
`define NVAC_RDY_IE_BIT 3
`define NVAC_ARM_BIT 2
`define NVAC_WSTB_BIT 1
`define NVAC_RSTB_BIT 0

// Timing
`define NVAC_ARM_CYCLES 3'h4
`define NVAC_WR_STALL 3'h2
`define NVAC_RD_STALL 3'h4
`define NVAC_WR_TICKS 14'h2100
`define NVAC_OSC_HZ 1000000
`define NVAC_CLK_HZ 40000000
`define NVAC_OSC_DIV (`NVAC_CLK_HZ / `NVAC_OSC_HZ)

`endif

// ==== rtl/nvac_pkg.sv ====
package nvac_pkg;

  // One I/O-space access from the core
  typedef struct packed {
    logic rd;
    logic wr;
    logic [5:0] addr;
    logic [7:0] wdata;
  } nvac_io_req_t;

  // Request toward the storage array
  typedef struct packed {
    logic rd;
    logic wr;
    logic [8:0] addr;
    logic [7:0] wdata;
  } nvac_mem_req_t;

  typedef enum logic [1:0] {
    NVAC_IDLE,
    NVAC_WRITING
  } nvac_state_t;

endpackage

// ==== rtl/nvac_tick.sv ====
`timescale 1ns/10ps
`include "nvac_defines.svh"
// Divider giving a one-cycle pulse at the calibrated oscillator rate
module nvac_tick #(
  parameter int DIV = `NVAC_OSC_DIV
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_nrst,
  // Tick out
  output logic o_tick
);

  initial begin
    if (DIV < 2) $error("nvac_tick: DIV must be at least 2");
  end

  logic [15:0] cnt_q;
  wire logic wrap = (cnt_q == 16'(DIV - 1));

  // Free-running count, restarts each wrap
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      cnt_q <= 16'h0000;
    end else begin
      cnt_q <= wrap ? 16'h0000 : cnt_q + 16'h0001;
    end
  end

  assign o_tick = wrap;
endmodule

// ==== rtl/nvac_store.sv ====
`timescale 1ns/10ps
// Byte-wide storage array, combinational read
module nvac_store #(
  parameter int DEPTH = 512
) (
  // Clock
  input wire logic i_clk,
  // Access
  input wire nvac_pkg::nvac_mem_req_t i_req,
  output logic [7:0] o_rdata
);

  initial begin
    if (DEPTH > 512 || DEPTH < 1) $error("nvac_store: DEPTH out of range");
  end

  logic [7:0] mem [DEPTH];

  // Program a byte at the end of the write time
  always_ff @(posedge i_clk) begin
    if (i_req.wr) begin
      mem[i_req.addr] <= i_req.wdata;
    end
  end

  assign o_rdata = mem[i_req.addr];
endmodule

// ==== tb/nvac_ctrl_properties.sv ====
`timescale 1ns/10ps
// Port checks of the access controller
module nvac_ctrl_properties (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_nrst,
  // Core side
  input wire nvac_pkg::nvac_io_req_t i_io,
  input wire logic i_bit_op,
  input wire logic [7:0] o_rdata,
  input wire logic o_hit,
  input wire logic i_gie,
  input wire logic i_flash_selfprog_active,
  input wire logic o_stall,
  input wire logic o_ready_irq,
  input wire logic o_busy
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_nrst);
  // Control decodes
  wire ctl = i_io.addr == 6'h1C;
  wire go = i_io.wr && ctl && i_io.wdata[1] && !o_busy;
  wire rs = i_io.wr && ctl && i_io.wdata[0] && !o_busy;
  property p_irq; ctl && !i_io.wr |-> o_ready_irq == (o_rdata[3] && i_gie && !o_rdata[1]); endproperty
  a_irq: assert property (p_irq) else $error("ready irq wrong");
  property p_ctl; ctl |-> o_rdata[7:4] == 4'h0 && !o_rdata[0]; endproperty
  a_ctl: assert property (p_ctl) else $error("control bits wrong");
  property p_hi; i_io.addr == 6'h1F |-> o_rdata[7:1] == 7'h00; endproperty
  a_hi: assert property (p_hi) else $error("address high wrong");
  property p_go; go && o_rdata[2] && !i_flash_selfprog_active |=> o_busy; endproperty
  a_go: assert property (p_go) else $error("write not started");
  property p_noarm; go && !o_rdata[2] |=> !o_busy; endproperty
  a_noarm: assert property (p_noarm) else $error("unarmed write");
  property p_flash; go && i_flash_selfprog_active |=> !o_busy; endproperty
  a_flash: assert property (p_flash) else $error("write during flash");
  property p_wst; $rose(o_busy) |-> o_stall ##1 o_stall ##1 !o_stall; endproperty
  a_wst: assert property (p_wst) else $error("write stall wrong");
  property p_rst; rs |=> o_stall [*4] ##1 !o_stall; endproperty
  a_rst: assert property (p_rst) else $error("read stall wrong");
  c_wr: cover property (go ##1 o_busy);
  c_rd: cover property (rs);
  c_irq: cover property (o_ready_irq);
endmodule
bind nvac_ctrl nvac_ctrl_properties nvac_ctrl_properties_i (.i_clk(i_clk), .i_nrst(i_nrst), .i_io(i_io),
  .i_bit_op(i_bit_op), .o_rdata(o_rdata), .o_hit(o_hit), .i_gie(i_gie),
  .i_flash_selfprog_active(i_flash_selfprog_active), .o_stall(o_stall), .o_ready_irq(o_ready_irq), .o_busy(o_busy));

// ==== tb/nvac_cpu.sv ====
`timescale 1ns/10ps
// Core side issuing I/O accesses
module nvac_cpu (
  // Clock and stall
  input wire logic i_clk,
  input wire logic i_stall,
  // Access out
  output nvac_pkg::nvac_io_req_t o_io
);
  initial o_io = '{1'b0, 1'b0, 6'h00, 8'h00};
  // Wait out the stall
  task automatic hold;
    @(negedge i_clk);
    while (i_stall === 1'b1) @(negedge i_clk);
  endtask
  // One-cycle write, data scrambled after
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    hold;
    o_io = '{1'b0, 1'b1, a, d};
    @(negedge i_clk);
    o_io = '{1'b0, 1'b0, a, ~d};
  endtask
  // Point the read mux
  task automatic rd(input logic [5:0] a);
    hold;
    o_io = '{1'b1, 1'b0, a, o_io.wdata};
  endtask
endmodule

// ==== tb/test_nvac_ctrl.sv ====
`timescale 1ns/10ps
// Bench for the access controller
module test_nvac_ctrl;
  localparam int WT = 4;
  localparam int DV = 4;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic gie = 1'b0;
  logic flash = 1'b0;
  logic bop = 1'b0;
  nvac_pkg::nvac_io_req_t io;
  logic [7:0] rdata;
  logic hit, stall, irq, busy;
  int err_total = 0;
  int compares = 0;
  int n;
  // Address and byte per row
  logic [16:0] rows [3] = '{{9'h000, 8'hA5}, {9'h1FF, 8'h5A}, {9'h0FF, 8'h00}};
  always #12.5 clk = ~clk;
  nvac_cpu nvac_cpu_i (.i_clk(clk), .i_stall(stall), .o_io(io));
  nvac_ctrl #(.WR_TICKS(WT), .OSC_DIV(DV)) nvac_ctrl_i (.i_clk(clk), .i_nrst(nrst), .i_io(io), .i_bit_op(bop),
    .o_rdata(rdata), .o_hit(hit), .i_gie(gie), .i_flash_selfprog_active(flash), .o_stall(stall),
    .o_ready_irq(irq), .o_busy(busy));
  task automatic cmp(input logic [7:0] g, input logic [7:0] e);
    compares++;
    if (g !== e) begin
      err_total++;
      $display("BAD %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic w(input logic [5:0] a, input logic [7:0] d);
    nvac_cpu_i.wr(a, d);
  endtask
  task automatic chk(input logic [5:0] a, input logic [7:0] e);
    nvac_cpu_i.rd(a);
    #1 cmp(rdata, e);
  endtask
  // Load the byte address, low then high
  task automatic ld(input logic [8:0] a);
    w(6'h1E, a[7:0]);
    w(6'h1F, {7'h00, a[8]});
  endtask
  // Armed write, interrupts kept off
  task automatic go(input logic [8:0] a, input logic [7:0] d);
    ld(a);
    w(6'h1D, d);
    w(6'h1C, 8'h04);
    w(6'h1C, 8'h06);
    cmp({7'h00, stall}, 8'h01);
  endtask
  task automatic fin;
    for (n = 0; n < 99 && busy !== 1'b0; n++) @(negedge clk);
  endtask
  task automatic get(input logic [8:0] a, input logic [7:0] e);
    ld(a);
    w(6'h1C, 8'h01);
    cmp({7'h00, stall}, 8'h01);
    chk(6'h1D, e);
  endtask
  task automatic results;
    $display("compares %0d errors %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (3) @(negedge clk);
    nrst = 1'b1;
    foreach (rows[i]) begin
      go(rows[i][16:8], rows[i][7:0]);
      fin;
      cmp(8'(n >= (WT - 1) * DV && n <= WT * DV + 2), 8'h01);
      chk(6'h1C, 8'h00);
      get(rows[i][16:8], rows[i][7:0]);
    end
    ld(9'h000);
    w(6'h1D, 8'h11);
    w(6'h1C, 8'h02);
    w(6'h1C, 8'h04);
    repeat (6) @(negedge clk);
    w(6'h1C, 8'h02);
    flash = 1'b1;
    w(6'h1C, 8'h04);
    w(6'h1C, 8'h06);
    flash = 1'b0;
    get(9'h000, 8'hA5);
    go(9'h055, 8'h3C);
    @(negedge clk) nrst = 1'b0;
    @(negedge clk) nrst = 1'b1;
    w(6'h1E, 8'h77);
    w(6'h1C, 8'h01);
    cmp({7'h00, stall}, 8'h00);
    chk(6'h1D, 8'h3C);
    fin;
    chk(6'h1E, 8'h55);
    get(9'h055, 8'h3C);
    gie = 1'b1;
    bop = 1'b1;
    w(6'h1C, 8'h08);
    bop = 1'b0;
    #1 cmp({7'h00, irq}, 8'h01);
    gie = 1'b0;
    #1 cmp({7'h00, irq}, 8'h00);
    w(6'h1C, 8'h00);
    w(6'h1F, 8'hFF);
    chk(6'h1F, 8'h01);
    cmp({7'h00, hit}, 8'h01);
    chk(6'h20, 8'h00);
    cmp({7'h00, hit}, 8'h00);
    results;
  end
  // Hang guard
  initial begin
    #100000;
    err_total++;
    results;
  end
endmodule
